// File: src/aub_fifo_mem.sv
`timescale 1ns/1ps
`default_nettype none
module aub_fifo_mem
    import aub_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              we,
    input  wire logic [AUB_AW-1:0] waddr,
    input  wire logic [7:0]        wdata,
    input  wire logic [AUB_AW-1:0] raddr,
    output logic      [7:0]        rdata
);
    logic [7:0] mem [0:AUB_DEPTH-1];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Write-through so a byte pushed into an empty buffer is visible one cycle later.
    always_ff @(posedge clk) begin
        if (we && (waddr == raddr)) begin
            rdata <= wdata;
        end else begin
            rdata <= mem[raddr];
        end
    end
endmodule
`default_nettype wire

// File: src/aub_pkg.sv
package aub_pkg;

    localparam int          AUB_DEPTH     = 128;
    localparam int          AUB_AW        = 7;
    localparam logic [7:0]  AUB_DEPTH_C   = 8'h80;
    localparam logic [3:0]  AUB_GAP_MAX   = 4'h8;
    localparam logic [3:0]  AUB_GAP_SAT   = 4'h9;
    localparam logic [7:0]  AUB_Q_FRAME   = 8'h0c;
    localparam logic [7:0]  AUB_TX_HIGH   = 8'h70;
    localparam logic [7:0]  AUB_TX_LOW    = 8'h10;
    localparam logic [1:0]  AUB_TX_GAP    = 2'h3;
    localparam logic [2:0]  AUB_LAST_BIT  = 3'h7;

    localparam logic [3:0]  AUB_ADR_CTRL  = 4'h0;
    localparam logic [3:0]  AUB_ADR_STAT  = 4'h4;
    localparam logic [3:0]  AUB_ADR_DATA  = 4'h8;
    localparam int          AUB_CTRL_TX   = 0;
    localparam int          AUB_CTRL_Q    = 1;
    localparam int          AUB_CTRL_CLR  = 2;
    localparam int          AUB_STAT_OVR  = 0;
    localparam int          AUB_STAT_RDY  = 1;
    localparam int          AUB_STAT_CNT  = 8;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } aub_wb_req_s;

    typedef struct packed {
        logic valid;
        logic data;
    } aub_ubit_s;

    typedef enum logic [1:0] {AUB_TX_IDLE, AUB_TX_DATA, AUB_TX_ZERO} aub_tx_e;
    typedef enum logic {AUB_RX_SEARCH, AUB_RX_CAPTURE} aub_rx_e;

    function automatic logic aub_hit(input logic [3:0] adr, input logic [3:0] off);
        aub_hit = (adr == off);
    endfunction

endpackage

// File: src/aub_rx_extract.sv
`timescale 1ns/1ps
`default_nettype none
module aub_rx_extract
    import aub_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      rst_n,
    input  wire aub_ubit_s ubit,
    input  wire logic      q_mode,
    input  wire logic      flush,
    output logic           byte_valid,
    output logic [7:0]     byte_data
);
    aub_rx_e    state_reg;
    logic [2:0] bit_cnt_reg;
    logic [6:0] shift_reg;
    logic [3:0] zero_cnt_reg;
    logic       msg_start_reg;
    logic [6:0] q_sh_reg;
    logic [2:0] q_cnt_reg;

    always_ff @(posedge clk) begin
        if (!rst_n || flush) begin
            state_reg     <= AUB_RX_SEARCH;
            bit_cnt_reg   <= 3'h0;
            shift_reg     <= 7'h00;
            zero_cnt_reg  <= AUB_GAP_SAT;
            msg_start_reg <= 1'b1;
        end else if (ubit.valid) begin
            case (state_reg)
                AUB_RX_SEARCH: begin
                    if (ubit.data) begin
                        state_reg     <= AUB_RX_CAPTURE;
                        shift_reg     <= 7'h01;
                        bit_cnt_reg   <= 3'h1;
                        msg_start_reg <= (zero_cnt_reg > AUB_GAP_MAX);
                    end else if (zero_cnt_reg != AUB_GAP_SAT) begin
                        zero_cnt_reg <= zero_cnt_reg + 4'h1;
                    end
                end
                AUB_RX_CAPTURE: begin
                    shift_reg   <= {shift_reg[5:0], ubit.data};
                    bit_cnt_reg <= bit_cnt_reg + 3'h1;
                    if (bit_cnt_reg == AUB_LAST_BIT) begin
                        state_reg    <= AUB_RX_SEARCH;
                        zero_cnt_reg <= 4'h0;
                    end
                end
                default: state_reg <= AUB_RX_SEARCH;
            endcase
        end
    end

    // Q bit is the second bit of every byte; eight of them pack into one stored byte.
    always_ff @(posedge clk) begin
        if (!rst_n || flush) begin
            q_sh_reg  <= 7'h00;
            q_cnt_reg <= 3'h0;
        end else if (ubit.valid && state_reg == AUB_RX_CAPTURE && bit_cnt_reg == 3'h1) begin
            q_sh_reg  <= {q_sh_reg[5:0], ubit.data};
            q_cnt_reg <= q_cnt_reg + 3'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || flush) begin
            byte_valid <= 1'b0;
            byte_data  <= 8'h00;
        end else begin
            byte_valid <= 1'b0;
            if (ubit.valid && state_reg == AUB_RX_CAPTURE) begin
                if (!q_mode && bit_cnt_reg == AUB_LAST_BIT) begin
                    byte_valid <= 1'b1;
                    byte_data  <= {msg_start_reg, shift_reg[5:0], ubit.data};
                end else if (q_mode && bit_cnt_reg == 3'h1 && q_cnt_reg == AUB_LAST_BIT) begin
                    byte_valid <= 1'b1;
                    byte_data  <= {q_sh_reg, ubit.data};
                end
            end
        end
    end

    a_gap_boundary: assert property (@(posedge clk) disable iff (!rst_n)
        ubit.valid && ubit.data && state_reg == AUB_RX_SEARCH && !flush
        |=> msg_start_reg == ($past(zero_cnt_reg) > AUB_GAP_MAX))
        else $error("message start flag does not follow the zero gap length");
endmodule
`default_nettype wire

// File: src/aub_top.sv
// Function
// - More than eight zeros separate two messages.
// - Up to eight zeros keep one message.
// - Link bytes go MSB first, start bit one.
// - Q mode delivers twelve bytes per frame.
// - Normal mode stores bytes, drops gap zeros.
// - First message byte MSB one, others zero.
// - Buffer is a 128-byte FIFO.
// - Normal mode ready low while any byte is held.
// - Serial read shifts each byte LSB first.
// - Q bits packed eight per byte, earliest MSB.
// - Q mode ready low at twelve or more.
// - Clear command empties buffer, ready goes high in receive.
// - Full buffer stops writes, overrun flag sets.
// - Reads of empty buffer return zero.
// - Transmit ready high at 112, low at 16.
// - Transmit sends zero bits when buffer empty.
// - Transmit writes to full buffer refused, overrun.
// - Transmit inserts four zeros between bytes.
//
// The placing of the registers and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module aub_top
    import aub_pkg::*;
(
    input  wire logic          CLK_SYS,
    input  wire logic          RST_N,
    input  wire aub_wb_req_s   WB_REQ,
    output logic               WB_ACK,
    output logic        [31:0] WB_DAT,
    input  wire aub_ubit_s     UBIT_RX,
    input  wire logic          UBIT_TX_REQ,
    output logic               UBIT_TX,
    input  wire logic          SER_SHIFT,
    output logic               SER_DATA,
    output logic               USER_DATA_READY_N
);
    logic              tx_mode_reg;
    logic              q_mode_reg;
    logic              ack_reg;
    logic       [31:0] dat_reg;
    logic              rd_got_reg;
    logic [AUB_AW-1:0] wr_ptr_reg;
    logic [AUB_AW-1:0] rd_ptr_reg;
    logic        [7:0] count_reg;
    logic        [7:0] count_next;
    logic              overrun_reg;
    logic              ready_n_reg;
    logic              ready_n_next;
    logic        [7:0] mem_rdata;
    logic              ext_valid;
    logic        [7:0] ext_byte;
    aub_tx_e           tx_state_reg;
    logic        [2:0] tx_cnt_reg;
    logic        [7:0] tx_sh_reg;
    logic        [2:0] ser_cnt_reg;
    logic        [6:0] ser_sh_reg;
    logic              wb_req;
    logic              wb_take;
    logic              wr_ctrl;
    logic              wr_stat;
    logic              wr_data;
    logic              rd_data;
    logic              clear;
    logic              empty;
    logic              full;
    logic              push_req;
    logic              push;
    logic        [7:0] push_byte;
    logic              pop;
    logic              tx_load;
    logic              ser_load;

    assign wb_req  = WB_REQ.cyc && WB_REQ.stb;
    assign wb_take = wb_req && ack_reg;
    assign wr_ctrl = wb_take && WB_REQ.we && WB_REQ.sel[0] && aub_hit(WB_REQ.adr, AUB_ADR_CTRL);
    assign wr_stat = wb_take && WB_REQ.we && WB_REQ.sel[0] && aub_hit(WB_REQ.adr, AUB_ADR_STAT);
    assign wr_data = wb_take && WB_REQ.we && WB_REQ.sel[0] && aub_hit(WB_REQ.adr, AUB_ADR_DATA);
    assign rd_data = wb_take && !WB_REQ.we && aub_hit(WB_REQ.adr, AUB_ADR_DATA);
    assign clear   = wr_ctrl && WB_REQ.dat[AUB_CTRL_CLR];
    assign empty   = (count_reg == 8'h00);
    assign full    = (count_reg == AUB_DEPTH_C);

    // Receive fills from the link, transmit from the host; never both at once.
    assign push_req  = tx_mode_reg ? wr_data : ext_valid;
    assign push_byte = tx_mode_reg ? WB_REQ.dat[7:0] : ext_byte;
    assign push      = push_req && !full && !clear;
    assign tx_load   = tx_mode_reg && UBIT_TX_REQ && tx_state_reg == AUB_TX_IDLE && !empty;
    assign ser_load  = !tx_mode_reg && SER_SHIFT && ser_cnt_reg == 3'h0 && !empty && !wb_req;
    assign pop       = !clear && (tx_load || ser_load || (rd_data && rd_got_reg));

    aub_rx_extract u_extract (
        .clk        (CLK_SYS),
        .rst_n      (RST_N),
        .ubit       (UBIT_RX),
        .q_mode     (q_mode_reg),
        .flush      (clear || tx_mode_reg),
        .byte_valid (ext_valid),
        .byte_data  (ext_byte)
    );

    aub_fifo_mem u_mem (
        .clk   (CLK_SYS),
        .we    (push),
        .waddr (wr_ptr_reg),
        .wdata (push_byte),
        .raddr (rd_ptr_reg),
        .rdata (mem_rdata)
    );

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            tx_mode_reg <= 1'b0;
            q_mode_reg  <= 1'b0;
        end else if (wr_ctrl) begin
            tx_mode_reg <= WB_REQ.dat[AUB_CTRL_TX];
            q_mode_reg  <= WB_REQ.dat[AUB_CTRL_Q];
        end
    end

    // One wait state: the answer always comes in the cycle after the request is seen.
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            ack_reg    <= 1'b0;
            dat_reg    <= 32'h0000_0000;
            rd_got_reg <= 1'b0;
        end else begin
            ack_reg <= wb_req && !ack_reg;
            if (wb_req && !ack_reg && !WB_REQ.we) begin
                rd_got_reg <= 1'b0;
                dat_reg    <= 32'h0000_0000;
                if (aub_hit(WB_REQ.adr, AUB_ADR_CTRL)) begin
                    dat_reg[AUB_CTRL_TX] <= tx_mode_reg;
                    dat_reg[AUB_CTRL_Q]  <= q_mode_reg;
                end else if (aub_hit(WB_REQ.adr, AUB_ADR_STAT)) begin
                    dat_reg[AUB_STAT_OVR]                <= overrun_reg;
                    dat_reg[AUB_STAT_RDY]                <= ready_n_reg;
                    dat_reg[AUB_STAT_CNT+7:AUB_STAT_CNT] <= count_reg;
                end else if (aub_hit(WB_REQ.adr, AUB_ADR_DATA) && !tx_mode_reg && !empty) begin
                    dat_reg[7:0] <= mem_rdata;
                    rd_got_reg   <= 1'b1;
                end
            end
        end
    end

    assign WB_ACK = ack_reg;
    assign WB_DAT = dat_reg;

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N || clear) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 7'h01;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 7'h01;
            end
        end
    end

    always_comb begin
        count_next = count_reg;
        if (clear) begin
            count_next = 8'h00;
        end else if (push && !pop) begin
            count_next = count_reg + 8'h01;
        end else if (pop && !push) begin
            count_next = count_reg - 8'h01;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            count_reg <= 8'h00;
        end else begin
            count_reg <= count_next;
        end
    end

    // A refused byte in the same cycle as a software clear still leaves the flag set.
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            overrun_reg <= 1'b0;
        end else if (push_req && full) begin
            overrun_reg <= 1'b1;
        end else if (wr_stat && WB_REQ.dat[AUB_STAT_OVR]) begin
            overrun_reg <= 1'b0;
        end
    end

    always_comb begin
        ready_n_next = ready_n_reg;
        // The new mode is not in force yet, so a clear into receive raises ready here.
        if (clear && !WB_REQ.dat[AUB_CTRL_TX]) begin
            ready_n_next = 1'b1;
        end else if (tx_mode_reg) begin
            if (count_next >= AUB_TX_HIGH) begin
                ready_n_next = 1'b1;
            end else if (count_next <= AUB_TX_LOW) begin
                ready_n_next = 1'b0;
            end
        end else if (q_mode_reg) begin
            ready_n_next = (count_next < AUB_Q_FRAME);
        end else begin
            ready_n_next = (count_next == 8'h00);
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            ready_n_reg <= 1'b1;
        end else begin
            ready_n_reg <= ready_n_next;
        end
    end

    assign USER_DATA_READY_N = ready_n_reg;

    // Outgoing link: each request gets one bit in the next cycle.
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N || !tx_mode_reg) begin
            tx_state_reg <= AUB_TX_IDLE;
            tx_cnt_reg   <= 3'h0;
            tx_sh_reg    <= 8'h00;
            UBIT_TX      <= 1'b0;
        end else if (UBIT_TX_REQ) begin
            case (tx_state_reg)
                AUB_TX_IDLE: begin
                    if (!empty) begin
                        UBIT_TX      <= mem_rdata[7];
                        tx_sh_reg    <= {mem_rdata[6:0], 1'b0};
                        tx_cnt_reg   <= 3'h1;
                        tx_state_reg <= AUB_TX_DATA;
                    end else begin
                        UBIT_TX <= 1'b0;
                    end
                end
                AUB_TX_DATA: begin
                    UBIT_TX    <= tx_sh_reg[7];
                    tx_sh_reg  <= {tx_sh_reg[6:0], 1'b0};
                    tx_cnt_reg <= tx_cnt_reg + 3'h1;
                    if (tx_cnt_reg == AUB_LAST_BIT) begin
                        tx_state_reg <= AUB_TX_ZERO;
                        tx_cnt_reg   <= 3'h0;
                    end
                end
                AUB_TX_ZERO: begin
                    UBIT_TX    <= 1'b0;
                    tx_cnt_reg <= tx_cnt_reg + 3'h1;
                    if (tx_cnt_reg[1:0] == AUB_TX_GAP) begin
                        tx_state_reg <= AUB_TX_IDLE;
                    end
                end
                default: tx_state_reg <= AUB_TX_IDLE;
            endcase
        end
    end

    // Serial read path; a shift on an empty buffer yields zero bits.
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N || clear || tx_mode_reg) begin
            ser_cnt_reg <= 3'h0;
            ser_sh_reg  <= 7'h00;
            SER_DATA    <= 1'b0;
        end else if (SER_SHIFT && !wb_req) begin
            ser_cnt_reg <= ser_cnt_reg + 3'h1;
            if (ser_cnt_reg == 3'h0) begin
                SER_DATA   <= empty ? 1'b0 : mem_rdata[0];
                ser_sh_reg <= empty ? 7'h00 : mem_rdata[7:1];
            end else begin
                SER_DATA   <= ser_sh_reg[0];
                ser_sh_reg <= {1'b0, ser_sh_reg[6:1]};
            end
        end
    end

    a_fifo_bound: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        count_reg <= AUB_DEPTH_C)
        else $error("buffer count above capacity");

    a_full_refuse: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        push_req && full && !pop && !clear |=> count_reg == AUB_DEPTH_C && overrun_reg)
        else $error("write into full buffer not refused or not flagged");

    a_clear_empty: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        clear && !WB_REQ.dat[AUB_CTRL_TX] |=> count_reg == 8'h00 && USER_DATA_READY_N ##1 WB_ACK == 1'b0)
        else $error("clear did not empty the buffer and raise ready");

    a_rx_ready: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        !tx_mode_reg && !q_mode_reg && $stable(q_mode_reg) && $stable(tx_mode_reg)
        |-> USER_DATA_READY_N == (count_reg == 8'h00))
        else $error("ready does not track non-empty buffer");

    a_q_ready: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        !tx_mode_reg && q_mode_reg && $stable(q_mode_reg) && $stable(tx_mode_reg)
        |-> USER_DATA_READY_N == (count_reg < AUB_Q_FRAME))
        else $error("Q mode ready does not track twelve bytes");

    a_tx_hyst: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        tx_mode_reg && $stable(tx_mode_reg) |->
        (count_reg >= AUB_TX_HIGH -> USER_DATA_READY_N) && (count_reg <= AUB_TX_LOW -> !USER_DATA_READY_N))
        else $error("transmit ready thresholds violated");

    a_tx_empty_zero: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        tx_mode_reg && UBIT_TX_REQ && tx_state_reg == AUB_TX_IDLE && empty |=> !UBIT_TX)
        else $error("nonzero bit sent from empty buffer");

    a_tx_msb_first: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        tx_load && !wr_ctrl |=> UBIT_TX == $past(mem_rdata[7]) && tx_state_reg == AUB_TX_DATA)
        else $error("transmit byte not sent MSB first");

    a_tx_gap_zero: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        tx_mode_reg && UBIT_TX_REQ && tx_state_reg == AUB_TX_ZERO && !wr_ctrl
        |=> !UBIT_TX ##0 (tx_state_reg == AUB_TX_IDLE) == ($past(tx_cnt_reg[1:0]) == AUB_TX_GAP))
        else $error("gap between transmit bytes is not four zeros");

    a_ser_lsb_first: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        ser_load && !wr_ctrl |=> SER_DATA == $past(mem_rdata[0]))
        else $error("serial read not LSB first");

    a_empty_read: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        wb_req && !ack_reg && !WB_REQ.we && aub_hit(WB_REQ.adr, AUB_ADR_DATA) && empty
        |=> WB_ACK && WB_DAT == 32'h0000_0000)
        else $error("empty buffer read returned nonzero data");

    a_overrun_hold: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        overrun_reg && !(wr_stat && WB_REQ.dat[AUB_STAT_OVR]) |=> overrun_reg)
        else $error("overrun flag lost without a clear");

    a_tx_refuse: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        tx_mode_reg && wr_data && full |=> overrun_reg && wr_ptr_reg == $past(wr_ptr_reg))
        else $error("transmit write into full buffer not refused");

    c_overrun: cover property (@(posedge CLK_SYS) disable iff (!RST_N) push_req && full);
    c_q_ready: cover property (@(posedge CLK_SYS) disable iff (!RST_N) q_mode_reg && !USER_DATA_READY_N);
    c_tx_gap: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
        tx_state_reg == AUB_TX_ZERO ##1 tx_state_reg == AUB_TX_IDLE);
    c_rd_pop: cover property (@(posedge CLK_SYS) disable iff (!RST_N) rd_data && rd_got_reg);
    c_ser_read: cover property (@(posedge CLK_SYS) disable iff (!RST_N) ser_load);
endmodule
`default_nettype wire

// File: testbench/aub_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module aub_host_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       go,
    input  wire logic       q_mode,
    input  wire logic       ready_n,
    input  wire logic       ser_data,
    output logic            ser_shift,
    output logic            got,
    output logic [7:0]      got_byte
);
    logic [4:0] ph_reg;
    logic       act_reg;
    logic [3:0] k_reg;
    always_ff @(posedge clk) begin
        ser_shift <= 1'b0;
        got <= 1'b0;
        if (!rst_n) begin
            act_reg <= 1'b0;
            ph_reg <= 5'h0;
            k_reg <= 4'h0;
        end else if (!act_reg) begin
            // A frame of twelve is read whole in Q mode, else the flag is polled per byte.
            act_reg <= go && (!ready_n || k_reg != 4'h0);
            ph_reg <= 5'h0;
        end else begin
            ph_reg <= ph_reg + 5'h1;
            ser_shift <= !ph_reg[0] && ph_reg < 5'h10;
            if (!ph_reg[0] && ph_reg != 5'h0 && ph_reg < 5'h12) begin
                got_byte <= {ser_data, got_byte[7:1]};
            end
            if (ph_reg == 5'h10) begin
                got <= 1'b1;
                k_reg <= (!q_mode || k_reg == 4'hb) ? 4'h0 : k_reg + 4'h1;
            end
            act_reg <= ph_reg != 5'h12;
        end
    end
endmodule
`default_nettype wire

// File: testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import aub_pkg::*;
    logic        CLK_SYS = 1'b0;
    logic        RST_N = 1'b0;
    aub_wb_req_s WB_REQ = '0;
    aub_ubit_s   UBIT_RX = '0;
    logic        UBIT_TX_REQ = 1'b0;
    logic        WB_ACK, UBIT_TX, SER_SHIFT, SER_DATA, RDY_N, got;
    logic [31:0] WB_DAT, rd;
    logic [7:0]  got_byte, b, qb;
    logic        go = 1'b0;
    logic        q_on = 1'b0;
    logic [7:0]  exp_q[$];
    int          err_total = 0;
    int          n_compared = 0;
    int          seed = 32'h4ec18ce5;
    always #20 CLK_SYS = ~CLK_SYS;
    aub_top u_dut (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .WB_REQ(WB_REQ), .WB_ACK(WB_ACK),
        .WB_DAT(WB_DAT), .UBIT_RX(UBIT_RX), .UBIT_TX_REQ(UBIT_TX_REQ), .UBIT_TX(UBIT_TX),
        .SER_SHIFT(SER_SHIFT), .SER_DATA(SER_DATA), .USER_DATA_READY_N(RDY_N));
    aub_host_model u_host (.clk(CLK_SYS), .rst_n(RST_N), .go(go), .q_mode(q_on),
        .ready_n(RDY_N), .ser_data(SER_DATA), .ser_shift(SER_SHIFT), .got(got),
        .got_byte(got_byte));
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
        n_compared++;
        if (s !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, e, s);
        end
    endtask
    function automatic logic [7:0] msg_byte(input logic [7:0] v, input logic first);
        return first ? v : {1'b0, v[6:0]};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge CLK_SYS);
    endtask
    task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge CLK_SYS);
        WB_REQ <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: d};
        do begin
            @(posedge CLK_SYS);
            n++;
            if (n > 20) begin
                err_total++;
                end_of_test();
            end
        end while (WB_ACK !== 1'b1);
        rd = WB_DAT;
        WB_REQ <= '0;
    endtask
    task automatic rx_bits(input logic [15:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge CLK_SYS);
            UBIT_RX <= '{valid: 1'b1, data: v[i]};
        end
        @(posedge CLK_SYS);
        UBIT_RX <= '0;
    endtask
    task automatic tx_bit(input logic e);
        @(posedge CLK_SYS);
        UBIT_TX_REQ <= 1'b1;
        @(posedge CLK_SYS);
        UBIT_TX_REQ <= 1'b0;
        @(posedge CLK_SYS);
        chk("tx bit", {31'h0, e}, {31'h0, UBIT_TX});
    endtask
    task automatic host_read(input int n);
        int t;
        go <= 1'b1;
        for (int k = 0; k < n; k++) begin
            t = 0;
            do begin
                @(posedge CLK_SYS);
                t++;
                if (t > 400) begin
                    err_total++;
                    end_of_test();
                end
            end while (got !== 1'b1);
            chk("serial byte", {24'h0, exp_q.pop_front()}, {24'h0, got_byte});
        end
        go <= 1'b0;
    endtask
    task automatic ready_is(input logic e);
        tick(4);
        chk("ready_n", {31'h0, e}, {31'h0, RDY_N});
    endtask
    initial begin
        tick(12);
        RST_N <= 1'b1;
        ready_is(1'b1);
        wb(1'b0, 4'hc, 32'h0);
        chk("unmapped", 32'h0, rd);
        wb(1'b0, AUB_ADR_DATA, 32'h0);
        chk("empty read", 32'h0, rd);
        // Three messages: in-message gaps none, random, and the longest legal one.
        for (int m = 0; m < 3; m++) begin
            for (int k = 0; k < 4; k++) begin
                b = 8'h80 | 8'($random(seed));
                rx_bits(16'h0, (k == 0) ? 9 : (m == 0) ? 0 : (m == 2) ? 8
                    : int'($unsigned($random(seed)) % 9));
                rx_bits({8'h0, b}, 8);
                exp_q.push_back(msg_byte(b, k == 0));
            end
        end
        ready_is(1'b0);
        host_read(12);
        ready_is(1'b1);
        wb(1'b1, AUB_ADR_CTRL, 32'h6);
        q_on <= 1'b1;
        for (int k = 0; k < 96; k++) begin
            b = 8'h80 | 8'($random(seed));
            qb = {qb[6:0], b[6]};
            if (k % 8 == 7) exp_q.push_back(qb);
            rx_bits({8'h0, b}, 8);
            rx_bits(16'h0, 9 * (k % 2));
            if (k == 87) ready_is(1'b1);
        end
        ready_is(1'b0);
        host_read(12);
        ready_is(1'b1);
        wb(1'b1, AUB_ADR_CTRL, 32'h4);
        q_on <= 1'b0;
        rx_bits(16'h0, 9);
        for (int k = 0; k < 130; k++) rx_bits(16'h80 | 16'(k % 128), 8);
        wb(1'b0, AUB_ADR_STAT, 32'h0);
        chk("rx count", 32'h80, {24'h0, rd[15:8]});
        chk("rx overrun", 32'h1, {31'h0, rd[0]});
        wb(1'b0, AUB_ADR_DATA, 32'h0);
        chk("fifo head", 32'h80, rd);
        rx_bits(16'h85, 8);
        wb(1'b0, AUB_ADR_STAT, 32'h0);
        chk("rx refill", 32'h80, {24'h0, rd[15:8]});
        wb(1'b1, AUB_ADR_STAT, 32'h1);
        wb(1'b1, AUB_ADR_CTRL, 32'h4);
        ready_is(1'b1);
        wb(1'b0, AUB_ADR_STAT, 32'h0);
        chk("cleared", 32'h0, {16'h0, rd[15:8], 7'h0, rd[0]});
        wb(1'b1, AUB_ADR_CTRL, 32'h5);
        for (int i = 0; i < 12; i++) tx_bit(1'b0);
        for (int k = 0; k < 129; k++) begin
            b = 8'($random(seed));
            if (k < 128) exp_q.push_back(b);
            wb(1'b1, AUB_ADR_DATA, {24'h0, b});
            if (k == 110) ready_is(1'b0);
            if (k == 111) ready_is(1'b1);
        end
        wb(1'b0, AUB_ADR_STAT, 32'h0);
        chk("tx overrun", 32'h8001, {16'h0, rd[15:8], 7'h0, rd[0]});
        for (int k = 0; k < 128; k++) begin
            b = exp_q.pop_front();
            for (int i = 0; i < 12; i++) tx_bit((i < 8) ? b[7 - i] : 1'b0);
            if (k == 110) ready_is(1'b1);
            if (k == 111) ready_is(1'b0);
        end
        for (int i = 0; i < 4; i++) tx_bit(1'b0);
        end_of_test();
    end
endmodule
`default_nettype wire
